// ---- mct_top.sv ----
// Four groups of three programmable down-counters with card interrupt glue
// Contract
// - Offsets 0-2 data ports, offset 3 control
// - Bits 7:6 pick counter; 11 ignored
// - Code 00 latches a stable count snapshot
// - Low, high, or low-then-high byte transfers
// - Bits 3:1 pick mode, bit 3 partly ignored
// - Bit 0 picks binary or BCD counting
// - Range 0-65535 binary, 0-9999 BCD
// - Six modes: TC, one-shot, rate, square, strobes
// - Three 16-bit counters per group, DC-8MHz
// - Only the selected group answers accesses
// - Debounce clock: counter-11 output or 2MHz
// - Interrupt sources: counter-12 output, external input
// - Each source has its own enable
// - Readable status flag per source
// - Request latched until cleared, no re-raise
// - Global disable of interrupt request output
// - Counter 11 on 8MHz, 12 on 11
`timescale 1ns/1ps
module mct_top (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Host I/O window
    input wire logic [1:0] group_sel,
    input wire logic [1:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Counter pins
    input wire logic [9:0] cnt_clk_in,
    input wire logic clk8m_in,
    input wire logic clk2m_in,
    input wire logic [11:0] gate_in,
    output logic [11:0] cnt_out,
    // Card glue controls and status
    input wire logic dbclk_sel,
    input wire logic external_irq_input,
    input wire logic counter_irq_enable,
    input wire logic external_irq_enable,
    input wire logic irq_global_en,
    input wire logic clr_counter_irq,
    input wire logic clr_external_irq,
    output logic debounce_clock,
    output logic counter_irq_status,
    output logic external_irq_status,
    output logic irq_out
);
    // Reset release through two flops
    logic rst_meta_b;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_b <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_b <= 1'b1;
            rst_n <= rst_meta_b;
        end
    end

    // Pin synchronisers: a change is taken once stages two and three agree
    logic [mct_pkg::NUM_PINS-1:0] pin_raw, sync1_reg, sync2_reg, sync3_reg;
    logic [mct_pkg::NUM_PINS-1:0] filt_reg, filt_d_reg, filt_next;
    assign pin_raw = {gate_in, external_irq_input, clk2m_in, clk8m_in, cnt_clk_in};
    assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            filt_reg <= '0;
            filt_d_reg <= '0;
        end
        else if (clk_en)
        begin
            sync1_reg <= pin_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= filt_next;
            filt_d_reg <= filt_reg;
        end
    end

    mct_pkg::mct_cnt_t st_reg [mct_pkg::NUM_CNT];
    mct_pkg::mct_cnt_t st_next [mct_pkg::NUM_CNT];
    // Counter clocks; 11 runs from the 8MHz pin, 12 from counter 11's output
    logic [11:0] cclk, cclk_d_reg, tick, gate, grise;
    assign cclk = {st_reg[mct_pkg::CNT11_IDX].out_lvl, filt_reg[mct_pkg::PIN_CLK8M],
                   filt_reg[9:0]};
    assign tick = cclk_d_reg & ~cclk; // Count on the falling input edge
    assign gate = filt_reg[mct_pkg::PIN_GATE +: 12];
    assign grise = gate & ~filt_d_reg[mct_pkg::PIN_GATE +: 12];

    // Global counter index from group and port/select code
    function automatic logic [3:0] cidx(input logic [1:0] grp, input logic [1:0] sel);
        return {1'b0, grp, 1'b0} + {2'b00, grp} + {2'b00, sel};
    endfunction

    // Host decode; only the selected group is ever touched
    mct_pkg::mct_ctrl_t cw;
    logic wr_ctrl, wr_data, rd_data;
    logic [3:0] ctl_idx, dat_idx;
    assign cw = mct_pkg::mct_ctrl_t'(io_wdata);
    assign wr_ctrl = io_wr && io_addr == mct_pkg::OFS_CTRL
        && cw.sel != mct_pkg::SEL_ILLEGAL;
    assign wr_data = io_wr && io_addr != mct_pkg::OFS_CTRL;
    assign rd_data = io_rd && io_addr != mct_pkg::OFS_CTRL;
    assign ctl_idx = cidx(group_sel, cw.sel);
    assign dat_idx = cidx(group_sel, io_addr);

    // Next state of every counter: host effects first, then gate, then count edge
    always_comb
    begin
        mct_pkg::mct_cnt_t c;
        logic trig_mode;
        logic run;
        c = mct_pkg::CNT_RESET;
        trig_mode = 1'b0;
        run = 1'b0;
        for (int i = 0; i < mct_pkg::NUM_CNT; i++)
        begin
            c = st_reg[i];
            if (wr_ctrl && ctl_idx == 4'(i))
            begin
                if (cw.rw == mct_pkg::RW_LATCH)
                begin
                    if (!c.snap_valid)
                        c.snap = c.count; // Count keeps running behind the snapshot
                    c.snap_valid = 1'b1;
                end
                else
                begin
                    c.mode = mct_pkg::decode_mode(cw.mode);
                    c.rw = cw.rw;
                    c.bcd = cw.bcd;
                    c.rd_hi = 1'b0;
                    c.wr_hi = 1'b0;
                    c.pending_load = 1'b0;
                    c.has_cr = 1'b0;
                    c.armed = 1'b0;
                    c.trig = 1'b0;
                    c.snap_valid = 1'b0;
                    c.out_lvl = c.mode != mct_pkg::MODE_TC_IRQ;
                end
            end
            else if (wr_data && dat_idx == 4'(i))
            begin
                // Byte sequencing of the single data port
                case (c.rw)
                    mct_pkg::RW_LSB:
                    begin
                        c.reload = {8'h00, io_wdata};
                        c.pending_load = 1'b1;
                    end
                    mct_pkg::RW_MSB:
                    begin
                        c.reload = {io_wdata, 8'h00};
                        c.pending_load = 1'b1;
                    end
                    mct_pkg::RW_BOTH:
                    begin
                        if (!c.wr_hi)
                            c.reload[7:0] = io_wdata;
                        else
                            c.reload[15:8] = io_wdata;
                        c.pending_load = c.wr_hi;
                        c.wr_hi = !c.wr_hi;
                    end
                    default:
                        c.pending_load = 1'b0; // Unprogrammed counter ignores data
                endcase
                c.has_cr = c.has_cr | c.pending_load;
                if (c.mode == mct_pkg::MODE_TC_IRQ)
                    c.out_lvl = 1'b0;
            end
            else if (rd_data && dat_idx == 4'(i))
            begin
                if (c.rw == mct_pkg::RW_BOTH && !c.rd_hi)
                    c.rd_hi = 1'b1;
                else
                begin
                    c.rd_hi = 1'b0;
                    c.snap_valid = 1'b0; // Snapshot released after its last byte
                end
            end
            trig_mode = c.mode == mct_pkg::MODE_ONESHOT || c.mode == mct_pkg::MODE_HW_STROBE;
            if (grise[i])
                c.trig = 1'b1;
            if ((c.mode == mct_pkg::MODE_RATE || c.mode == mct_pkg::MODE_SQUARE) && !gate[i])
                c.out_lvl = 1'b1; // Gate low holds the output high
            run = trig_mode || gate[i];
            if (tick[i])
            begin
                if (c.mode == mct_pkg::MODE_SW_STROBE || c.mode == mct_pkg::MODE_HW_STROBE)
                    c.out_lvl = 1'b1; // Strobe lasts one input clock
                if ((c.pending_load && !trig_mode) || (trig_mode && c.trig && c.has_cr))
                begin
                    c.count = c.reload; // Zero means full span of 65536 or 10000
                    c.armed = 1'b1;
                    c.pending_load = 1'b0;
                    c.trig = 1'b0;
                    if (c.mode == mct_pkg::MODE_ONESHOT)
                        c.out_lvl = 1'b0;
                end
                else if (c.armed && run)
                begin
                    case (c.mode)
                        mct_pkg::MODE_TC_IRQ, mct_pkg::MODE_ONESHOT:
                        begin
                            if (c.count == mct_pkg::COUNT_ONE)
                                c.out_lvl = 1'b1;
                            c.count = mct_pkg::dec_cnt(c.count, c.bcd, 4'h1);
                        end
                        mct_pkg::MODE_RATE:
                        begin
                            c.out_lvl = c.count != mct_pkg::COUNT_TWO;
                            c.count = (c.count == mct_pkg::COUNT_ONE) ? c.reload
                                : mct_pkg::dec_cnt(c.count, c.bcd, 4'h1);
                        end
                        mct_pkg::MODE_SQUARE:
                        begin
                            // Odd counts are treated as the even value above
                            if (c.count == mct_pkg::COUNT_TWO || c.count == mct_pkg::COUNT_ONE)
                            begin
                                c.count = c.reload;
                                c.out_lvl = !c.out_lvl;
                            end
                            else
                                c.count = mct_pkg::dec_cnt(c.count, c.bcd, 4'h2);
                        end
                        default:
                        begin
                            if (c.count == mct_pkg::COUNT_ONE)
                            begin
                                c.out_lvl = 1'b0;
                                c.armed = 1'b0;
                            end
                            c.count = mct_pkg::dec_cnt(c.count, c.bcd, 4'h1);
                        end
                    endcase
                end
            end
            st_next[i] = c;
        end
    end

    // Read-back byte: snapshot wins over the live count
    mct_pkg::mct_cnt_t rd_st;
    logic [15:0] rd_val;
    logic [7:0] rd_byte;
    assign rd_st = (dat_idx < 4'(mct_pkg::NUM_CNT)) ? st_reg[dat_idx] : mct_pkg::CNT_RESET;
    assign rd_val = rd_st.snap_valid ? rd_st.snap : rd_st.count;
    assign rd_byte = (rd_st.rw == mct_pkg::RW_MSB || (rd_st.rw == mct_pkg::RW_BOTH && rd_st.rd_hi))
        ? rd_val[15:8] : rd_val[7:0];

    // Interrupt events; a set in the clearing cycle wins
    logic c12_rise, ext_rise, cnt_irq_next, ext_irq_next, out12_d_reg;
    assign c12_rise = st_reg[mct_pkg::CNT12_IDX].out_lvl & ~out12_d_reg;
    assign ext_rise = filt_reg[mct_pkg::PIN_EXT] & ~filt_d_reg[mct_pkg::PIN_EXT];
    assign cnt_irq_next = (counter_irq_status & ~clr_counter_irq)
        | (c12_rise & counter_irq_enable);
    assign ext_irq_next = (external_irq_status & ~clr_external_irq)
        | (ext_rise & external_irq_enable);

    // State registers; clk_en low freezes everything, host strobes included
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < mct_pkg::NUM_CNT; i++)
                st_reg[i] <= mct_pkg::CNT_RESET;
            cclk_d_reg <= '0;
            out12_d_reg <= 1'b0;
            io_rdata <= 8'h00;
            counter_irq_status <= 1'b0;
            external_irq_status <= 1'b0;
            irq_out <= 1'b0;
            debounce_clock <= 1'b0;
        end
        else if (clk_en)
        begin
            for (int i = 0; i < mct_pkg::NUM_CNT; i++)
                st_reg[i] <= st_next[i];
            cclk_d_reg <= cclk;
            out12_d_reg <= st_reg[mct_pkg::CNT12_IDX].out_lvl;
            if (io_rd)
                io_rdata <= rd_data ? rd_byte : 8'h00;
            counter_irq_status <= cnt_irq_next;
            external_irq_status <= ext_irq_next;
            irq_out <= irq_global_en & (cnt_irq_next | ext_irq_next);
            debounce_clock <= (dbclk_sel == mct_pkg::DBCLK_2MHZ) ? filt_reg[mct_pkg::PIN_CLK2M]
                : st_reg[mct_pkg::CNT11_IDX].out_lvl;
        end
    end

    // Counter outputs straight from state flops
    always_comb
    begin
        for (int i = 0; i < mct_pkg::NUM_CNT; i++)
            cnt_out[i] = st_reg[i].out_lvl;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_ctrl_write;
        clk_en && wr_ctrl && cw.rw != mct_pkg::RW_LATCH;
    endsequence
    a_mode_decode: assert property (s_ctrl_write |=> st_reg[$past(ctl_idx)].mode
        == mct_pkg::decode_mode($past(cw.mode))) else $error("mode not decoded");
    a_bcd_select: assert property (s_ctrl_write |=> st_reg[$past(ctl_idx)].bcd
        == $past(io_wdata[0])) else $error("count format not taken");
    a_illegal_sel: assert property (io_wr && cw.sel == mct_pkg::SEL_ILLEGAL && clk_en
        && io_addr == mct_pkg::OFS_CTRL && group_sel != 2'h3 |=> $past(st_reg[ctl_idx].mode)
        == st_reg[$past(ctl_idx)].mode) else $error("illegal select acted");
    a_latch_snap: assert property (clk_en && wr_ctrl && cw.rw == mct_pkg::RW_LATCH
        && !st_reg[ctl_idx].snap_valid |=> st_reg[$past(ctl_idx)].snap_valid
        && st_reg[$past(ctl_idx)].snap == $past(st_reg[ctl_idx].count))
        else $error("latch missed count");
    a_irq_hold: assert property (counter_irq_status && !clr_counter_irq && clk_en
        |=> counter_irq_status) else $error("counter request dropped");
    a_irq_enable: assert property (!counter_irq_enable && !counter_irq_status && clk_en
        |=> !counter_irq_status) else $error("disabled source raised");
    a_irq_global: assert property (clk_en && !irq_global_en |=> !irq_out)
        else $error("request with global disable");
    a_dbclk_route: assert property (clk_en && dbclk_sel == mct_pkg::DBCLK_COUNTER11
        |=> debounce_clock == $past(st_reg[mct_pkg::CNT11_IDX].out_lvl))
        else $error("debounce clock misrouted");
endmodule

// ---- mct_pkg.sv ----
// Shared constants, types and helpers for the multi-group counter/timer block
package mct_pkg;
    // Host window: three data ports and one control byte per counter group
    localparam logic [1:0] OFS_CNT0 = 2'h0;
    localparam logic [1:0] OFS_CNT1 = 2'h1;
    localparam logic [1:0] OFS_CNT2 = 2'h2;
    localparam logic [1:0] OFS_CTRL = 2'h3;
    // Counter select code 11 never programs a counter
    localparam logic [1:0] SEL_ILLEGAL = 2'h3;
    // Read/load sequence codes
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB = 2'h1;
    localparam logic [1:0] RW_MSB = 2'h2;
    localparam logic [1:0] RW_BOTH = 2'h3;
    // Counter population and the cascaded pair
    localparam int NUM_GRP = 4;
    localparam int NUM_CNT = 12;
    localparam int CNT11_IDX = 10;
    localparam int CNT12_IDX = 11;
    // Synchronised pin vector layout
    localparam int PIN_CLK8M = 10;
    localparam int PIN_CLK2M = 11;
    localparam int PIN_EXT = 12;
    localparam int PIN_GATE = 13;
    localparam int NUM_PINS = 25;
    // Debounce clock select values
    localparam logic DBCLK_COUNTER11 = 1'b0;
    localparam logic DBCLK_2MHZ = 1'b1;
    // Count limits; a loaded zero means a full span
    localparam logic [15:0] BIN_MAX = 16'hffff;
    localparam logic [15:0] BCD_MAX = 16'h9999;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] COUNT_TWO = 16'h0002;
    // Highest counter input rate, and the fewest system cycles per input period
    localparam int CNT_CLK_MAX_HZ = 8000000;
    localparam int SYS_CLK_HZ = 10000000;
    localparam int MIN_SYS_PER_CNT = (SYS_CLK_HZ / CNT_CLK_MAX_HZ < 1) ? 1
        : SYS_CLK_HZ / CNT_CLK_MAX_HZ;

    typedef enum logic [2:0] {MODE_TC_IRQ, MODE_ONESHOT, MODE_RATE, MODE_SQUARE,
                              MODE_SW_STROBE, MODE_HW_STROBE} mct_mode_t;

    // Control byte layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] rw;
        logic [2:0] mode;
        logic bcd;
    } mct_ctrl_t;

    // State of one counter
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] snap;
        mct_mode_t mode;
        logic [1:0] rw;
        logic bcd;
        logic snap_valid;
        logic rd_hi;
        logic wr_hi;
        logic pending_load;
        logic has_cr;
        logic armed;
        logic trig;
        logic out_lvl;
    } mct_cnt_t;

    localparam mct_cnt_t CNT_RESET = mct_cnt_t'(0);

    // Mode field: bit 3 is a don't-care for modes 2 and 3
    function automatic mct_mode_t decode_mode(input logic [2:0] m);
        return m[1] ? mct_mode_t'({1'b0, m[1:0]}) : mct_mode_t'(m);
    endfunction

    // Down-count by step in binary or four-digit BCD, wrapping through zero
    function automatic logic [15:0] dec_cnt(input logic [15:0] v, input logic bcd,
                                            input logic [3:0] step);
        logic [15:0] r;
        logic [4:0] d;
        logic [3:0] b;
        r = v - {12'h000, step};
        b = step;
        if (bcd)
        begin
            for (int i = 0; i < 4; i++)
            begin
                d = {1'b0, v[i*4 +: 4]} - {1'b0, b};
                r[i*4 +: 4] = d[4] ? d[3:0] + 4'ha : d[3:0];
                b = d[4] ? 4'h1 : 4'h0;
            end
        end
        return r;
    endfunction
endpackage

// ---- mct_host_model.sv ----
// Host model: byte-wide I/O window master that notes the expected bytes of its counter reads
`timescale 1ns/1ps
module mct_host_model (
    // Clock
    input wire logic sys_clk,
    // I/O window
    output logic [1:0] group_sel,
    output logic [1:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    logic [7:0] exp_q[$];

    // Quiet bus at time zero
    initial
    begin
        group_sel = 2'h0;
        io_addr = 2'h0;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // One strobe cycle; the idle edge in between keeps two calls from colliding
    task automatic cycle(input logic [1:0] g, input logic [1:0] a, input logic wr,
                         input logic [7:0] d);
        @(posedge sys_clk);
        group_sel <= g;
        io_addr <= a;
        io_wr <= wr;
        io_rd <= ~wr;
        io_wdata <= d;
        @(posedge sys_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        io_wdata <= ~d; // Released data must not keep showing the last byte
    endtask

    // Control byte first, then the data bytes in the programmed order
    task automatic load(input logic [1:0] g, input mct_pkg::mct_ctrl_t w,
                        input logic [15:0] v);
        cycle(g, 2'h3, 1'b1, w);
        if (w.rw != mct_pkg::RW_MSB)
            cycle(g, w.sel, 1'b1, v[7:0]);
        if (w.rw[1])
            cycle(g, w.sel, 1'b1, v[15:8]);
    endtask

    // Optional latch command, then the bytes that the counter's sequence hands out
    task automatic read_cnt(input logic [1:0] g, input logic [1:0] c, input logic [1:0] rw,
                            input logic lat, input logic [15:0] e);
        if (lat)
            cycle(g, 2'h3, 1'b1, {c, mct_pkg::RW_LATCH, 4'h0});
        if (rw != mct_pkg::RW_MSB)
        begin
            exp_q.push_back(e[7:0]);
            cycle(g, c, 1'b0, 8'h00);
        end
        if (rw[1])
        begin
            exp_q.push_back(e[15:8]);
            cycle(g, c, 1'b0, 8'h00);
        end
    endtask
endmodule

// ---- test_multi_counter_timer_card_ctrl.sv ----
// Self-checking bench for the four-group counter/timer block
`timescale 1ns/1ps
module test_multi_counter_timer_card_ctrl;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [1:0] group_sel, io_addr;
    logic io_wr, io_rd;
    logic [7:0] io_wdata, io_rdata;
    logic [9:0] cnt_clk_in = 10'h000;
    logic clk8m_in = 1'b0;
    logic clk2m_in = 1'b0;
    logic [11:0] gate_in = 12'hfff;
    logic [11:0] cnt_out;
    logic dbclk_sel = 1'b0;
    logic external_irq_input = 1'b0;
    logic counter_irq_enable = 1'b0;
    logic external_irq_enable = 1'b0;
    logic irq_global_en = 1'b0;
    logic clr_counter_irq = 1'b0;
    logic clr_external_irq = 1'b0;
    logic debounce_clock, counter_irq_status, external_irq_status, irq_out;
    logic rd_taken = 1'b0;
    logic run8m = 1'b0;
    logic [11:0] flags;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;

    mct_top dut_u (.sys_clk, .rst_b, .clk_en, .group_sel, .io_addr, .io_wr, .io_rd,
        .io_wdata, .io_rdata, .cnt_clk_in, .clk8m_in, .clk2m_in, .gate_in, .cnt_out,
        .dbclk_sel, .external_irq_input, .counter_irq_enable, .external_irq_enable,
        .irq_global_en, .clr_counter_irq, .clr_external_irq, .debounce_clock,
        .counter_irq_status, .external_irq_status, .irq_out);
    mct_host_model host_u (.sys_clk, .group_sel, .io_addr, .io_wr, .io_rd, .io_wdata);

    // Flags packed as counter, external, request line
    assign flags = {9'h000, counter_irq_status, external_irq_status, irq_out};

    // Free-running system clock
    initial
    begin
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic cmp_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cmp_bits(input string n, input logic [11:0] e, input logic [11:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic give_verdict;
        if (miscompares == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Hang guard, well above the length of the sequence
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            give_verdict();
        end
    end

    // Read data is valid the cycle after the strobe is taken
    always @(posedge sys_clk)
        rd_taken <= io_rd & clk_en;
    always @(negedge sys_clk)
        if (rd_taken)
            cmp_byte("read data", host_u.exp_q.pop_front(), io_rdata);

    // Fixed-rate source for the cascaded pair; parks low when stopped
    always
    begin
        repeat (4) @(posedge sys_clk);
        clk8m_in <= run8m & ~clk8m_in;
    end

    // Slow pulses on all ten cnt_clk_in pins, wide enough to pass the synchroniser
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            cnt_clk_in <= 10'h3ff;
            repeat (4) @(posedge sys_clk);
            cnt_clk_in <= 10'h000;
            repeat (4) @(posedge sys_clk);
        end
        repeat (8) @(posedge sys_clk);
    endtask

    task automatic ext_pulse;
        @(posedge sys_clk);
        external_irq_input <= 1'b1;
        repeat (8) @(posedge sys_clk);
        external_irq_input <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask

    // Service both sources, as the host must before a new request can rise
    task automatic clear_flags;
        @(posedge sys_clk);
        clr_counter_irq <= 1'b1;
        clr_external_irq <= 1'b1;
        @(posedge sys_clk);
        clr_counter_irq <= 1'b0;
        clr_external_irq <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    // Four-digit decimal down-count, wrapping through zero
    function automatic logic [15:0] bcd_sub(input logic [15:0] v, input int k);
        int n;
        n = v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0];
        n = (n + 10000 - k) % 10000;
        return {4'(n / 1000), 4'(n / 100 % 10), 4'(n / 10 % 10), 4'(n % 10)};
    endfunction

    // Main sequence
    initial
    begin
        logic [15:0] v[9];
        logic [1:0] rws[9];
        logic [15:0] e;
        mct_pkg::mct_ctrl_t w;
        int k;
        void'($urandom(43));
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Every mode code: only mode 0 parks the output low
        for (int m = 7; m >= 0; m--)
        begin
            host_u.cycle(2'h0, 2'h3, 1'b1, {2'h0, 2'h1, 3'(m), 1'b0});
            repeat (3) @(posedge sys_clk);
            cmp_bits("counter output", 12'(m != 0), 12'(cnt_out[0]));
        end
        // Illegal select touches no counter; control location reads zero
        host_u.cycle(2'h1, 2'h3, 1'b1, {2'h0, 2'h1, 3'h2, 1'b0});
        host_u.cycle(2'h0, 2'h3, 1'b1, {mct_pkg::SEL_ILLEGAL, 2'h1, 3'h0, 1'b0});
        repeat (3) @(posedge sys_clk);
        cmp_bits("counter outputs", 12'h008, cnt_out);
        host_u.exp_q.push_back(8'h00);
        host_u.cycle(2'h0, 2'h3, 1'b0, 8'h00);
        // Random counts into nine counters of three groups, all byte orders
        for (int i = 0; i < 9; i++)
        begin
            rws[i] = (i % 3 != 2) ? 2'h3 : (i == 5) ? 2'h2 : 2'h1;
            w = {2'(i % 3), rws[i], (i % 3 == 2) ? 3'h4 : 3'h0, i % 3 == 1};
            v[i] = 16'($urandom());
            if (w.bcd)
                v[i] = {4'($urandom % 10), 4'($urandom % 10),
                        4'($urandom % 10), 4'($urandom % 10)};
            if (rws[i] == 2'h1)
                v[i] = {8'h00, 8'($urandom % 200 + 16)};
            if (rws[i] == 2'h2)
                v[i] = {8'($urandom % 200 + 1), 8'h00};
            host_u.load(2'(i / 3), w, v[i]);
        end
        k = $urandom % 8 + 2;
        pulse(k);
        for (int i = 0; i < 9; i++)
        begin
            e = (i % 3 == 1) ? bcd_sub(v[i], k - 1) : v[i] - 16'(k - 1);
            host_u.read_cnt(2'(i / 3), 2'(i % 3), rws[i], 1'b1, e);
        end
        // Snapshot holds while counting goes on
        host_u.cycle(2'h0, 2'h3, 1'b1, 8'h00);
        pulse(2);
        host_u.read_cnt(2'h0, 2'h0, 2'h3, 1'b0, v[0] - 16'(k - 1));
        host_u.read_cnt(2'h0, 2'h0, 2'h3, 1'b1, v[0] - 16'(k + 1));
        // External source: disabled, enabled, cleared, globally masked
        ext_pulse();
        cmp_bits("irq flags", 12'h000, flags);
        external_irq_enable <= 1'b1;
        irq_global_en <= 1'b1;
        ext_pulse();
        cmp_bits("irq flags", 12'h003, flags);
        clear_flags();
        cmp_bits("irq flags", 12'h000, flags);
        irq_global_en <= 1'b0;
        ext_pulse();
        cmp_bits("irq flags", 12'h002, flags);
        clear_flags();
        irq_global_en <= 1'b1;
        counter_irq_enable <= 1'b1;
        // Cascaded pair: counter 11 rate of two feeds counter 12 terminal count
        host_u.load(2'h3, {2'h1, 2'h1, 3'h2, 1'b0}, 16'h0002);
        host_u.load(2'h3, {2'h2, 2'h1, 3'h0, 1'b0}, 16'h0002);
        run8m <= 1'b1;
        for (int t = 0; t < 2000 && counter_irq_status !== 1'b1; t++)
            @(posedge sys_clk);
        run8m <= 1'b0;
        cmp_bits("irq flags", 12'h005, flags);
        // Debounce clock follows counter 11 or the 2 MHz pin
        for (int m = 0; m < 2; m++)
        begin
            host_u.cycle(2'h3, 2'h3, 1'b1, {2'h1, 2'h1, m ? 3'h2 : 3'h0, 1'b0});
            clk2m_in <= (m == 0);
            dbclk_sel <= 1'b0;
            repeat (6) @(posedge sys_clk);
            cmp_bits("debounce clock", 12'(m), 12'(debounce_clock));
            dbclk_sel <= 1'b1;
            repeat (6) @(posedge sys_clk);
            cmp_bits("debounce clock", 12'(m == 0), 12'(debounce_clock));
        end
        clear_flags();
        cmp_bits("irq flags", 12'h000, flags);
        // One-shot: low from the gate-triggered load until the count of three runs out
        host_u.load(2'h1, {2'h1, 2'h1, 3'h1, 1'b0}, 16'h0003);
        gate_in[4] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        gate_in[4] <= 1'b1;
        pulse(1);
        cmp_bits("one-shot output", 12'h000, 12'(cnt_out[4]));
        pulse(2);
        cmp_bits("one-shot output", 12'h000, 12'(cnt_out[4]));
        pulse(1);
        cmp_bits("one-shot output", 12'h001, 12'(cnt_out[4]));
        give_verdict();
    end
endmodule
